//--- core/eeprom_access_pkg.sv
package eeprom_access_pkg;

   // Register page and offsets inside the controller register set
   localparam logic [1:0] CFG_PAGE = 2'h3;
   localparam logic [3:0] CTRL_OFS = 4'h2;
   localparam logic [3:0] BUF_OFS = 4'h4;

   // Control register fields
   localparam int WSEL_BIT = 6;
   localparam int GO_BIT = 7;

   // Reset values
   localparam logic [15:0] BUF_RST = 16'h0000;
   localparam logic [47:0] STATION_RST = 48'h0000_0000_0000;
   localparam logic [15:0] WORD_RST = 16'h0000;

   // Highest programmable word address
   localparam logic [5:0] ADDR_MAX = 6'h3f;

   // Word addresses fetched by the autoload walk
   localparam logic [5:0] W_STA0 = 6'h00;
   localparam logic [5:0] W_STA1 = 6'h01;
   localparam logic [5:0] W_STA2 = 6'h02;
   localparam logic [5:0] W_COMPAT = 6'h07;
   localparam logic [5:0] W_NEED = 6'h08;
   localparam logic [5:0] W_VENDOR = 6'h09;
   localparam logic [5:0] W_DEVICE = 6'h0a;
   localparam logic [5:0] W_MODE = 6'h0b;
   localparam logic [2:0] LOAD_LAST = 3'h7;

   // Clock rates and printed times
   localparam int CORE_CLK_NS = 50;
   localparam int LINK_CLK_NS = 125;
   localparam int RST_MIN_NS = 480;
   localparam int LOAD_DLY_NS = 1000;
   localparam int SK_PERIOD_NS = 1200;

   // Derived cycle counts: least times round up, half period rounds down
   localparam int RST_MIN_CYC = (RST_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int LOAD_DLY_CYC = (LOAD_DLY_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int SK_HALF_RAW = (SK_PERIOD_NS / 2) / LINK_CLK_NS;
   localparam int SK_HALF_CYC = (SK_HALF_RAW < 1) ? 1 : SK_HALF_RAW;

   // Serial command framing, start bit then opcode
   localparam logic [2:0] OP_READ = 3'b110;
   localparam logic [2:0] OP_WRITE = 3'b101;
   localparam logic [8:0] OP_WREN = 9'b1_0011_0000;
   localparam logic [4:0] HDR_BITS = 5'd9;
   localparam logic [4:0] WR_BITS = 5'd25;
   localparam logic [4:0] DATA_BITS = 5'd16;

   // One word transfer handed to the serial engine
   typedef struct packed {
      logic write;
      logic [5:0] addr;
      logic [15:0] data;
   } eeprom_op_t;

   // Contents loaded from the device at reset
   typedef struct packed {
      logic [47:0] station_addr;
      logic [15:0] compat_word;
      logic [7:0] latency_need;
      logic [7:0] burst_need;
      logic [15:0] vendor_code;
      logic [15:0] device_code;
      logic [7:0] mode_config;
      logic [7:0] revision_code;
   } autoload_cfg_t;

endpackage

//--- core/eeprom_access.sv
`timescale 1ns/1ns
// Function
// R01: Software programs: control, address, data, poll.
// R02: Access_go high while busy, cleared after.
// R03: Out-of-order host access aborts programming.
// R04: Word buffer lives at page 3, 04H.
// R05: Each write replaces exactly one word.
// R06: Programmable addresses 00H to 3fH only.
// R07: Software reads: control, address, poll, read.
// R08: Buffer keeps read word until next change.
// R09: Autoload maps station, need, identity words.
// R10: Compatibility word 07H loaded at autoload.
// R11: Reset lows under 480ns are ignored.
// R12: Wait 1us after reset before loading.
// R13: Device drives serial clock, 1.2us period; the divider gives 1.0us (8 link cycles).
// R14: Autoload walks addresses, overwrites register file.
// R15: Clearing access_go aborts sequence at once.
// R16: Control at 02H, bit6 write, bit7 go.
// R17: Three-wire serial protocol, MSB first.
module eeprom_access (
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // System reset pin, noisy, active low
   input wire logic sys_rst_n,
   // Register port
   input wire logic [1:0] reg_page,
   input wire logic [3:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // Autoload results
   output eeprom_access_pkg::autoload_cfg_t cfg,
   output logic autoload_busy,
   // Serial link clock and pins
   input wire logic link_clk,
   output logic ee_cs,
   output logic ee_sk,
   output logic ee_di,
   input wire logic ee_do
);

   // Host sequence states
   typedef enum logic [4:0] {
      H_IDLE = 5'b00001,
      H_ADDR = 5'b00010,
      H_DATA = 5'b00100,
      H_RUN = 5'b01000,
      H_LOAD = 5'b10000
   } host_state_t;

   // Serial engine states
   typedef enum logic [5:0] {
      L_IDLE = 6'b000001,
      L_OUT = 6'b000010,
      L_IN = 6'b000100,
      L_GAP = 6'b001000,
      L_POLL = 6'b010000,
      L_ACK = 6'b100000
   } link_state_t;

   // Autoload walk index to word address
   function automatic logic [5:0] load_addr(input logic [2:0] idx);
      case (idx)
         3'h0: load_addr = eeprom_access_pkg::W_STA0;
         3'h1: load_addr = eeprom_access_pkg::W_STA1;
         3'h2: load_addr = eeprom_access_pkg::W_STA2;
         3'h3: load_addr = eeprom_access_pkg::W_COMPAT;
         3'h4: load_addr = eeprom_access_pkg::W_NEED;
         3'h5: load_addr = eeprom_access_pkg::W_VENDOR;
         3'h6: load_addr = eeprom_access_pkg::W_DEVICE;
         default: load_addr = eeprom_access_pkg::W_MODE;
      endcase
   endfunction

   // Register decode, used by reads and writes alike
   function automatic logic hit(input logic [1:0] pg, input logic [3:0] ofs,
                                input logic [3:0] want);
      hit = (pg == eeprom_access_pkg::CFG_PAGE) && (ofs == want);
   endfunction

   // ---------------- Core domain ----------------

   logic [1:0] rst_pin_ff; // Pin synchroniser
   logic [4:0] low_cnt_ff; // Length of current low pulse
   logic rst_seen; // Long enough low just released
   logic [4:0] dly_cnt_ff; // Delay before autoload
   logic dly_run_ff;
   logic [1:0] ack_sync_ff; // Engine done, synchronised
   logic ack_l_ff; // Engine done level, link domain
   logic ack_s;
   host_state_t hst_ff;
   logic wsel_ff; // write_select
   logic go_ff; // access_go
   logic req_ff; // Request level to engine
   eeprom_access_pkg::eeprom_op_t op_ff; // Held stable while req_ff high
   logic [15:0] buf_ff; // eeprom_word_buffer
   logic [2:0] load_idx_ff;
   logic [15:0] link_word_ff; // Engine result, read only under ack_s
   logic ctrl_wr, buf_wr, buf_rd, ctrl_rd, load_take;

   assign ctrl_wr = reg_wr && hit(reg_page, reg_addr, eeprom_access_pkg::CTRL_OFS); // R16
   assign buf_wr = reg_wr && hit(reg_page, reg_addr, eeprom_access_pkg::BUF_OFS); // R04
   assign ctrl_rd = reg_rd && hit(reg_page, reg_addr, eeprom_access_pkg::CTRL_OFS);
   assign buf_rd = reg_rd && hit(reg_page, reg_addr, eeprom_access_pkg::BUF_OFS);
   assign ack_s = ack_sync_ff[1];
   assign load_take = (hst_ff == H_LOAD) && req_ff && ack_s;

   // Reset pin passes two flops before the filter looks at it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rst_pin_ff <= 2'b11;
      end else begin
         rst_pin_ff <= {rst_pin_ff[0], sys_rst_n};
      end
   end

   // Glitch filter: count low time, saturating at the minimum
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         low_cnt_ff <= 5'h00;
      end else if (rst_pin_ff[1]) begin
         low_cnt_ff <= 5'h00;
      end else if (low_cnt_ff < 5'(eeprom_access_pkg::RST_MIN_CYC)) begin
         low_cnt_ff <= low_cnt_ff + 5'h01;
      end
   end

   // Short lows never reach the count and are dropped as noise
   assign rst_seen = rst_pin_ff[1] &&
                     (low_cnt_ff >= 5'(eeprom_access_pkg::RST_MIN_CYC)); // R11

   // Delay from recognised reset (or power-on) to the first read
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dly_cnt_ff <= 5'(eeprom_access_pkg::LOAD_DLY_CYC);
         dly_run_ff <= 1'b1;
      end else if (rst_seen) begin
         dly_cnt_ff <= 5'(eeprom_access_pkg::LOAD_DLY_CYC); // R12
         dly_run_ff <= 1'b1;
      end else if (dly_run_ff && dly_cnt_ff != 5'h00) begin
         dly_cnt_ff <= dly_cnt_ff - 5'h01; // R12
      end else begin
         dly_run_ff <= 1'b0;
      end
   end

   // Completion level from the engine
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_sync_ff <= 2'b00;
      end else begin
         ack_sync_ff <= {ack_sync_ff[0], ack_l_ff};
      end
   end

   // Host sequence, autoload walk and request handshake
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hst_ff <= H_LOAD;
         wsel_ff <= 1'b0;
         go_ff <= 1'b0;
         req_ff <= 1'b0;
         op_ff <= '0;
         buf_ff <= eeprom_access_pkg::BUF_RST;
         load_idx_ff <= 3'h0;
      end else if (rst_seen) begin
         // Recognised reset restarts the walk; a live transfer is dropped
         hst_ff <= H_LOAD; // R14
         go_ff <= 1'b0;
         req_ff <= 1'b0;
         load_idx_ff <= 3'h0;
      end else begin
         case (hst_ff)
            H_LOAD: begin
               // Successive addresses generated here, not by software
               if (load_take) begin
                  req_ff <= 1'b0;
                  if (load_idx_ff == eeprom_access_pkg::LOAD_LAST) begin
                     hst_ff <= H_IDLE;
                  end else begin
                     load_idx_ff <= load_idx_ff + 3'h1; // R14
                  end
               end else if (!req_ff && !ack_s && !dly_run_ff) begin
                  op_ff <= '{write: 1'b0, addr: load_addr(load_idx_ff), data: 16'h0000};
                  req_ff <= 1'b1; // R14
               end
            end
            H_IDLE: begin
               if (ctrl_wr) begin
                  wsel_ff <= reg_wdata[eeprom_access_pkg::WSEL_BIT]; // R16
                  if (reg_wdata[eeprom_access_pkg::GO_BIT]) begin
                     go_ff <= 1'b1; // R02
                     hst_ff <= H_ADDR;
                  end
               end else if (buf_wr) begin
                  buf_ff <= reg_wdata;
               end
            end
            H_ADDR: begin
               if (ctrl_wr) begin
                  // Any control write here is either a clear or a violation
                  wsel_ff <= reg_wdata[eeprom_access_pkg::WSEL_BIT];
                  go_ff <= 1'b0; // R15
                  hst_ff <= H_IDLE; // R03
               end else if (buf_rd && wsel_ff) begin
                  go_ff <= 1'b0; // R03
                  hst_ff <= H_IDLE;
               end else if (buf_wr) begin
                  buf_ff <= reg_wdata; // R08
                  op_ff.addr <= reg_wdata[5:0];
                  op_ff.write <= wsel_ff;
                  if (wsel_ff && reg_wdata[15:0] > 16'(eeprom_access_pkg::ADDR_MAX)) begin
                     go_ff <= 1'b0; // R06
                     hst_ff <= H_IDLE;
                  end else if (wsel_ff) begin
                     hst_ff <= H_DATA; // R01
                  end else begin
                     hst_ff <= H_RUN; // R07
                  end
               end
            end
            H_DATA: begin
               if (ctrl_wr || buf_rd) begin
                  if (ctrl_wr) begin
                     wsel_ff <= reg_wdata[eeprom_access_pkg::WSEL_BIT];
                  end
                  go_ff <= 1'b0; // R03
                  hst_ff <= H_IDLE;
               end else if (buf_wr) begin
                  buf_ff <= reg_wdata;
                  op_ff.data <= reg_wdata; // R05
                  hst_ff <= H_RUN; // R01
               end
            end
            H_RUN: begin
               if (ctrl_wr && !reg_wdata[eeprom_access_pkg::GO_BIT]) begin
                  // Dropping the request makes the engine deselect now
                  wsel_ff <= reg_wdata[eeprom_access_pkg::WSEL_BIT];
                  go_ff <= 1'b0; // R15
                  req_ff <= 1'b0;
                  hst_ff <= H_IDLE;
               end else if (ctrl_wr || buf_wr) begin
                  go_ff <= 1'b0; // R03
                  req_ff <= 1'b0;
                  hst_ff <= H_IDLE;
               end else if (req_ff && ack_s) begin
                  if (!op_ff.write) begin
                     buf_ff <= link_word_ff; // R08
                  end
                  go_ff <= 1'b0; // R02
                  req_ff <= 1'b0;
                  hst_ff <= H_IDLE;
               end else if (!req_ff && !ack_s) begin
                  // Raised only once the previous handshake has retired
                  req_ff <= 1'b1; // R01
               end
            end
            default: begin
               hst_ff <= H_IDLE;
            end
         endcase
      end
   end

   // Register file filled from the walk, overwriting older values
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg <= '0;
      end else if (load_take) begin
         case (op_ff.addr)
            eeprom_access_pkg::W_STA0: cfg.station_addr[15:0] <= link_word_ff; // R09
            eeprom_access_pkg::W_STA1: cfg.station_addr[31:16] <= link_word_ff; // R09
            eeprom_access_pkg::W_STA2: cfg.station_addr[47:32] <= link_word_ff; // R09
            eeprom_access_pkg::W_COMPAT: cfg.compat_word <= link_word_ff; // R10
            eeprom_access_pkg::W_NEED: begin
               cfg.latency_need <= link_word_ff[15:8]; // R09
               cfg.burst_need <= link_word_ff[7:0];
            end
            eeprom_access_pkg::W_VENDOR: cfg.vendor_code <= link_word_ff; // R09
            eeprom_access_pkg::W_DEVICE: cfg.device_code <= link_word_ff; // R09
            default: begin
               cfg.mode_config <= link_word_ff[15:8]; // R09
               cfg.revision_code <= link_word_ff[7:0];
            end
         endcase
      end
   end

   // Read data registered, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (ctrl_rd) begin
         reg_rdata <= {8'h00, go_ff, wsel_ff, 6'h00}; // R02
      end else if (buf_rd) begin
         reg_rdata <= buf_ff; // R08
      end else if (reg_rd) begin
         reg_rdata <= 16'h0000;
      end
   end

   assign autoload_busy = (hst_ff == H_LOAD);

   // ---------------- Link domain ----------------

   logic [1:0] lrst_ff; // Reset release into link domain
   logic lrst;
   logic [1:0] req_sync_ff;
   logic req_s;
   logic [1:0] do_sync_ff;
   logic [2:0] div_ff; // Serial clock half period count
   logic fall_tick, rise_tick;
   link_state_t lst_ff;
   logic phase_ff; // High once the enable command has gone out
   logic [24:0] sh_ff;
   logic [4:0] cnt_ff;

   // Local reset: asserted at once, released on link edges
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         lrst_ff <= 2'b11;
      end else begin
         lrst_ff <= {lrst_ff[0], 1'b0};
      end
   end
   assign lrst = lrst_ff[1];

   // Request level and data-out pin synchronisers
   always_ff @(posedge link_clk or posedge lrst) begin
      if (lrst) begin
         req_sync_ff <= 2'b00;
         do_sync_ff <= 2'b00;
      end else begin
         req_sync_ff <= {req_sync_ff[0], req_ff};
         do_sync_ff <= {do_sync_ff[0], ee_do};
      end
   end
   assign req_s = req_sync_ff[1];

   // Free-running divider; the device itself makes the serial clock
   always_ff @(posedge link_clk or posedge lrst) begin
      if (lrst) begin
         div_ff <= 3'h0;
         ee_sk <= 1'b0;
      end else if (div_ff == 3'(eeprom_access_pkg::SK_HALF_CYC - 1)) begin
         div_ff <= 3'h0;
         ee_sk <= ~ee_sk; // R13
      end else begin
         div_ff <= div_ff + 3'h1;
      end
   end
   assign rise_tick = (div_ff == 3'(eeprom_access_pkg::SK_HALF_CYC - 1)) && !ee_sk;
   assign fall_tick = (div_ff == 3'(eeprom_access_pkg::SK_HALF_CYC - 1)) && ee_sk;

   // Serial engine: commands go out MSB first on falling edges,
   // the part samples on rising edges, where read data is taken too
   always_ff @(posedge link_clk or posedge lrst) begin
      if (lrst) begin
         lst_ff <= L_IDLE;
         ack_l_ff <= 1'b0;
         phase_ff <= 1'b0;
         sh_ff <= '0;
         cnt_ff <= 5'h00;
         ee_cs <= 1'b0;
         ee_di <= 1'b0;
         link_word_ff <= 16'h0000;
      end else if (!req_s && lst_ff != L_IDLE && lst_ff != L_ACK) begin
         // Request withdrawn mid-transfer: deselect, which cancels a write
         lst_ff <= L_IDLE; // R15
         ee_cs <= 1'b0;
         ee_di <= 1'b0;
      end else begin
         case (lst_ff)
            L_IDLE: begin
               if (req_s && fall_tick) begin
                  ee_cs <= 1'b1; // R17
                  cnt_ff <= eeprom_access_pkg::HDR_BITS;
                  phase_ff <= 1'b0;
                  if (op_ff.write) begin
                     sh_ff <= {eeprom_access_pkg::OP_WREN, 16'h0000};
                  end else begin
                     sh_ff <= {eeprom_access_pkg::OP_READ, op_ff.addr, 16'h0000};
                  end
                  lst_ff <= L_OUT;
               end
            end
            L_OUT: begin
               if (fall_tick && cnt_ff != 5'h00) begin
                  ee_di <= sh_ff[24]; // R17
                  sh_ff <= {sh_ff[23:0], 1'b0};
                  cnt_ff <= cnt_ff - 5'h01;
               end else if (fall_tick) begin
                  ee_di <= 1'b0;
                  if (!op_ff.write) begin
                     cnt_ff <= eeprom_access_pkg::DATA_BITS;
                     lst_ff <= L_IN;
                  end else begin
                     ee_cs <= 1'b0;
                     lst_ff <= L_GAP;
                  end
               end
            end
            L_IN: begin
               if (rise_tick) begin
                  link_word_ff <= {link_word_ff[14:0], do_sync_ff[1]}; // R17
                  cnt_ff <= cnt_ff - 5'h01;
                  if (cnt_ff == 5'h01) begin
                     lst_ff <= L_ACK;
                  end
               end
            end
            L_GAP: begin
               // One full serial clock with select low between commands
               if (fall_tick && !phase_ff) begin
                  phase_ff <= 1'b1;
                  ee_cs <= 1'b1;
                  sh_ff <= {eeprom_access_pkg::OP_WRITE, op_ff.addr, op_ff.data}; // R05
                  cnt_ff <= eeprom_access_pkg::WR_BITS;
                  lst_ff <= L_OUT;
               end else if (fall_tick) begin
                  ee_cs <= 1'b1;
                  lst_ff <= L_POLL;
               end
            end
            L_POLL: begin
               // Data-out high marks the internal write as finished
               if (rise_tick && do_sync_ff[1]) begin
                  lst_ff <= L_ACK; // R02
               end
            end
            L_ACK: begin
               ee_cs <= 1'b0;
               ack_l_ff <= req_s;
               if (!req_s) begin
                  lst_ff <= L_IDLE;
               end
            end
            default: begin
               lst_ff <= L_IDLE;
            end
         endcase
      end
   end

endmodule

//--- bench/eeprom_access_properties.sv
`timescale 1ns/1ns
module eeprom_access_properties (
   // Clocks and resets
   input wire logic core_clk,
   input wire logic rst,
   input wire logic link_clk,
   // Watched signals
   input wire logic sys_rst_n,
   input wire logic [1:0] reg_page,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic autoload_busy,
   input wire logic ee_cs,
   input wire logic ee_sk,
   input wire logic ee_di
);
   // Long low, then release
   sequence long_low;
      !sys_rst_n [*8] ##1 !sys_rst_n [*6] ##1 sys_rst_n;
   endsequence
   // Four-cycle glitch while idle
   sequence short_low;
      !autoload_busy && $fell(sys_rst_n) ##1 !sys_rst_n [*3] ##1 sys_rst_n;
   endsequence
   a_unmapped_read: assert property (@(posedge core_clk) disable iff (rst)
      reg_rd && reg_page != eeprom_access_pkg::CFG_PAGE |=> reg_rdata == 16'h0000)
      else $error("unmapped read nonzero");
   a_rdata_hold: assert property (@(posedge core_clk) disable iff (rst)
      !reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
   a_load_wait: assert property (@(posedge core_clk) disable iff (rst)
      $fell(rst) |-> (autoload_busy && !ee_cs) [*8]) else $error("early autoload");
   a_noise_ignored: assert property (@(posedge core_clk) disable iff (rst)
      short_low |=> !autoload_busy [*8]) else $error("glitch reloaded");
   a_reset_reload: assert property (@(posedge core_clk) disable iff (rst)
      long_low |-> ##[1:30] autoload_busy) else $error("no reload");
   a_sk_period: assert property (@(posedge link_clk) disable iff (rst)
      $rose(ee_sk) |-> ee_sk [*4] ##1 !ee_sk [*4] ##1 ee_sk)
      else $error("sk period");
   a_di_on_fall: assert property (@(posedge link_clk) disable iff (rst)
      ee_cs && $changed(ee_di) |-> !ee_sk) else $error("di moved, sk high");
   a_cs_on_low: assert property (@(posedge link_clk) disable iff (rst)
      $rose(ee_cs) |-> !ee_sk) else $error("cs rose, sk high");
endmodule

bind eeprom_access eeprom_access_properties u_props (.core_clk(core_clk), .rst(rst),
   .link_clk(link_clk), .sys_rst_n(sys_rst_n), .reg_page(reg_page), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .autoload_busy(autoload_busy), .ee_cs(ee_cs), .ee_sk(ee_sk),
   .ee_di(ee_di));

//--- bench/eeprom_model.sv
`timescale 1ns/1ns
// x16 serial memory behind the link pins
module eeprom_model (
   // Serial pins
   input wire logic ee_cs,
   input wire logic ee_sk,
   input wire logic ee_di,
   output logic ee_do
);
   logic [15:0] mem [0:63]; // Word store, filled by the bench
   logic [24:0] sh = '0; // Bits taken since select
   logic [15:0] rd_sh; // Word being sent
   logic wen = 1'b0; // Write enable latch
   logic pend = 1'b0; // Write status still owed
   int nbit = 0; // Bit count in this select
   int rd_left = 0; // Read bits still to send
   int busy = 0; // Programming time left, in clock periods
   int wr_wait = 2; // Programming time, set by the bench
   initial ee_do = 1'b0;
   // Fresh framing on each select; an aborted read is forgotten
   always @(posedge ee_cs) begin
      nbit = 0;
      sh = '0;
      rd_left = 0;
   end
   // Commands shifted in on rising clock, most significant bit first
   always @(posedge ee_sk) begin
      if (busy > 0)
         busy--;
      // Leading zeros before the start bit are ignored
      if (ee_cs && rd_left == 0 && !pend && (nbit > 0 || ee_di)) begin
         sh = {sh[23:0], ee_di};
         nbit++;
         if (nbit == 9 && sh[8:6] == 3'b110) begin
            rd_sh = mem[sh[5:0]];
            rd_left = 16;
         end
         if (nbit == 9 && sh[8:4] == 5'b10011)
            wen = 1'b1;
         if (nbit == 25 && sh[24:22] == 3'b101 && wen) begin
            mem[sh[21:16]] = sh[15:0];
            busy = wr_wait;
            pend = 1'b1;
         end
      end
   end
   // Data out on falling clock; an idle line never keeps its last level
   always @(negedge ee_sk) begin
      if (ee_cs && rd_left > 0) begin
         ee_do = rd_sh[15];
         rd_sh = rd_sh << 1;
         rd_left--;
      end else if (ee_cs && pend) begin
         ee_do = (busy == 0);
         pend = (busy != 0);
      end else
         ee_do = ~ee_do;
   end
endmodule

//--- bench/tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
   $display("ERROR at %0t got %h exp %h", $time, (got), (exp)); end end
module tb;
   // Design inputs
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst = 1'b1;
   logic sys_rst_n = 1'b1;
   logic [1:0] reg_page = 2'h3;
   logic [3:0] reg_addr = 4'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   // Design outputs
   logic [15:0] reg_rdata;
   eeprom_access_pkg::autoload_cfg_t cfg;
   logic autoload_busy, ee_cs, ee_sk, ee_di, ee_do;
   // Reference memory
   logic [15:0] exp_mem [0:63];
   logic [15:0] v; // Last value read
   logic [5:0] w; // Word address under test
   int n_fail = 0;
   int compares = 0;
   int seed = 32'h3fcf;
   int a;
   localparam logic [3:0] CTL = eeprom_access_pkg::CTRL_OFS;
   localparam logic [3:0] BUF = eeprom_access_pkg::BUF_OFS;
   // Core 50 ns, link 125 ns
   always #25 core_clk = ~core_clk;
   always begin
      #62 link_clk = 1'b1;
      #63 link_clk = 1'b0;
   end
   eeprom_access DUT (.core_clk(core_clk), .rst(rst), .sys_rst_n(sys_rst_n),
      .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg(cfg), .autoload_busy(autoload_busy),
      .link_clk(link_clk), .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do));
   eeprom_model u_ee (.ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do));
   // One register access from a falling edge
   task automatic acc(input logic wr, input logic [3:0] ofs, input logic [15:0] d,
      output logic [15:0] q);
      reg_addr = ofs;
      reg_wdata = d;
      reg_wr = wr;
      reg_rd = ~wr;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      @(negedge core_clk);
      q = reg_rdata;
   endtask
   // Poll access_go until it drops, bounded
   task automatic poll(input logic busy0);
      int k;
      k = 0;
      acc(1'b0, CTL, 16'h0000, v);
      if (busy0) `CHK(v[7], 1'b1)
      while (v[7] !== 1'b0 && k < 4000) begin
         acc(1'b0, CTL, 16'h0000, v);
         k++;
      end
      `CHK(v[7], 1'b0)
   endtask
   // Programming sequence; out of range changes nothing
   task automatic ee_write(input logic [15:0] adr, input logic [15:0] d);
      acc(1'b1, CTL, 16'h00c0, v);
      acc(1'b1, BUF, adr, v);
      acc(1'b1, BUF, d, v);
      if (adr <= 16'h003f)
         exp_mem[adr[5:0]] = d;
      poll(adr <= 16'h003f);
   endtask
   // Read sequence, result checked in the buffer
   task automatic ee_read(input logic [5:0] adr);
      acc(1'b1, CTL, 16'h0080, v);
      acc(1'b1, BUF, {10'h000, adr}, v);
      poll(1'b1);
      acc(1'b0, BUF, 16'h0000, v);
      `CHK(v, exp_mem[adr])
   endtask
   // Wait out the walk, compare every field
   task automatic load_check();
      int k;
      k = 0;
      repeat (30) @(negedge core_clk);
      while (autoload_busy !== 1'b0 && k < 20000) begin
         @(negedge core_clk);
         k++;
      end
      `CHK(autoload_busy, 1'b0)
      `CHK(cfg.station_addr, {exp_mem[2], exp_mem[1], exp_mem[0]})
      `CHK(cfg.compat_word, exp_mem[7])
      `CHK({cfg.latency_need, cfg.burst_need}, exp_mem[8])
      `CHK({cfg.vendor_code, cfg.device_code}, {exp_mem[9], exp_mem[10]})
      `CHK({cfg.mode_config, cfg.revision_code}, exp_mem[11])
   endtask
   // Low pulse on the system reset pin, in core cycles
   task automatic pulse(input int n);
      sys_rst_n = 1'b0;
      repeat (n) @(negedge core_clk);
      sys_rst_n = 1'b1;
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      for (a = 0; a < 64; a++) begin
         exp_mem[a] = 16'($random(seed));
         u_ee.mem[a] = exp_mem[a];
      end
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
      load_check();
      reg_page = 2'h2;
      acc(1'b0, BUF, 16'h0000, v);
      `CHK(v, 16'h0000)
      reg_page = 2'h3;
      $display("test autoload done");
      // Boundary and random words: write, read back; last one slow
      for (a = 0; a < 3; a++) begin
         w = (a == 0) ? 6'h00 : (a == 1) ? 6'h3f : 6'($random(seed));
         u_ee.wr_wait = 2 + a * 30;
         ee_write({10'h000, w}, 16'($random(seed)));
         ee_read(w);
      end
      acc(1'b0, BUF, 16'h0000, v);
      `CHK(v, exp_mem[w])
      $display("test write read done");
      // Refused writes: address past the top, then a read out of order
      ee_write(16'h0040, 16'($random(seed)));
      ee_read(6'h00);
      acc(1'b1, CTL, 16'h00c0, v);
      acc(1'b1, BUF, 16'h0005, v);
      acc(1'b0, BUF, 16'h0000, v);
      poll(1'b0);
      ee_read(6'h05);
      // Clearing access_go mid transfer drops the select
      acc(1'b1, CTL, 16'h0080, v);
      acc(1'b1, BUF, 16'h0011, v);
      repeat (100) @(negedge core_clk);
      acc(1'b1, CTL, 16'h0000, v);
      poll(1'b0);
      repeat (20) @(negedge core_clk);
      `CHK(ee_cs, 1'b0)
      $display("test abort done");
      // Glitch ignored, long pulse reloads fresh contents
      pulse(4);
      repeat (40) @(negedge core_clk);
      `CHK(autoload_busy, 1'b0)
      exp_mem[9] = ~exp_mem[9];
      u_ee.mem[9] = exp_mem[9];
      pulse(14);
      load_check();
      $display("test system reset done");
      end_of_test();
   end
   // Watchdog, well past the expected run
   initial begin
      #4000000;
      n_fail++;
      end_of_test();
   end
endmodule
